// ### asr_pkg.sv
// Shared constants for the accessory switch register block.
`default_nettype none

package asr_pkg;
  // ==========================================================================
  // Register indices (word address on the register bus)
  localparam int ASR_ADDR_W = 6;
  localparam logic [5:0] ASR_IDX_CONTROL = 6'h02;
  localparam logic [5:0] ASR_IDX_TYPE = 6'h0a;
  localparam logic [5:0] ASR_IDX_RAW = 6'h0b;
  localparam logic [5:0] ASR_IDX_ROUTE = 6'h13;
  localparam logic [5:0] ASR_IDX_CHARGE = 6'h14;
  localparam logic [5:0] ASR_IDX_MATCH = 6'h1b;
  localparam logic [5:0] ASR_IDX_TUNE = 6'h1c;
  localparam logic [5:0] ASR_IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] ASR_IDX_IRQ_MASK = 6'h21;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] ASR_RST_CONTROL = 8'h00;
  localparam logic [7:0] ASR_RST_ROUTE = 8'h27;
  localparam logic [7:0] ASR_RST_CHARGE = 8'h00;
  localparam logic [7:0] ASR_RST_MATCH = 8'h08;
  localparam logic [7:0] ASR_RST_TUNE = 8'h05;
  localparam logic [7:0] ASR_RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] ASR_WMASK_CONTROL = 8'h01;
  localparam logic [7:0] ASR_WMASK_ROUTE = 8'hff;
  localparam logic [7:0] ASR_WMASK_CHARGE = 8'h1c;
  localparam logic [7:0] ASR_WMASK_MATCH = 8'h1c;
  localparam logic [7:0] ASR_WMASK_TUNE = 8'h0f;
  localparam logic [7:0] ASR_WMASK_IRQ = 8'h07;

  // ==========================================================================
  // Field positions
  localparam int ASR_CTRL_ROUTE_EN = 0;
  localparam int ASR_TYPE_DOCK = 5;
  localparam int ASR_TYPE_DCP = 2;
  localparam int ASR_TYPE_CDP = 1;
  localparam int ASR_TYPE_SDP = 0;
  localparam int ASR_NEG_LSB = 5;
  localparam int ASR_POS_LSB = 2;
  localparam int ASR_PWR_LSB = 0;
  localparam int ASR_CHG_FORCE_DET = 4;
  localparam int ASR_CHG_MIC_GUARD = 3;
  localparam int ASR_CHG_FORCE_0V6 = 2;
  localparam int ASR_MATCH_LSB = 2;
  localparam int ASR_CHECK_LSB = 2;
  localparam int ASR_CAP_LSB = 0;
  localparam int ASR_IRQ_ATTACH = 0;
  localparam int ASR_IRQ_CODE = 1;
  localparam int ASR_IRQ_RAIL = 2;

  // ==========================================================================
  // Routing codes
  localparam logic [2:0] ASR_DATA_OPEN = 3'h0;
  localparam logic [2:0] ASR_DATA_HOST1 = 3'h1;
  localparam logic [2:0] ASR_DATA_AUDIO = 3'h2;
  localparam logic [2:0] ASR_DATA_HOST2 = 3'h3;
  localparam logic [2:0] ASR_DATA_MIC = 3'h4;
  localparam logic [1:0] ASR_PWR_OPEN = 2'h0;
  localparam logic [1:0] ASR_PWR_MIC = 2'h2;
  localparam logic [1:0] ASR_PWR_OUT = 2'h3;

  // A count field encodes its count minus one.
  function automatic logic [3:0] asr_need(input logic [2:0] field);
    asr_need = {1'b0, field} + 4'h1;
  endfunction
endpackage

`default_nettype wire

// ### asr_id_filter.sv
// ID reading filter: attach and resistor-code-change qualification.
`default_nettype none

module asr_id_filter
  import asr_pkg::*;
#(
  parameter int CODE_W = 5
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Readings.
  input wire logic sample_valid,
  input wire logic [CODE_W-1:0] sample_code,
  // Tuning.
  input wire logic [2:0] match_field,
  input wire logic [1:0] check_field,
  // Results.
  output logic attached,
  output logic attach_pulse,
  output logic change_pulse
);
  // Codes wider than a byte are not served by the reading path.
  if (CODE_W < 1 || CODE_W > 8) begin : g_code_w_check
    $error("CODE_W out of range");
  end

  logic [CODE_W-1:0] stable_reg;
  logic [CODE_W-1:0] cand_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] need;
  logic attached_reg;
  logic attach_pulse_reg;
  logic change_pulse_reg;
  logic hit;

  // A run counts consecutive identical readings that differ from the stable code.
  always_comb begin
    need = attached_reg ? asr_need({1'b0, check_field}) : asr_need(match_field);
    if (sample_code == cand_reg && cnt_reg != 4'h0) begin
      cnt_next = cnt_reg + 4'h1;
    end else begin
      cnt_next = 4'h1;
    end
    hit = sample_valid && sample_code != stable_reg && cnt_next >= need;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= 4'h0;
      cand_reg <= '0;
    end else if (sample_valid) begin
      cand_reg <= sample_code;
      cnt_reg <= (sample_code == stable_reg || hit) ? 4'h0 : cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stable_reg <= '0;
      attached_reg <= 1'b0;
      attach_pulse_reg <= 1'b0;
      change_pulse_reg <= 1'b0;
    end else begin
      attach_pulse_reg <= hit && !attached_reg;
      change_pulse_reg <= hit && attached_reg;
      if (hit) begin
        stable_reg <= sample_code;
        attached_reg <= sample_code != '0;
      end
    end
  end

  assign attached = attached_reg;
  assign attach_pulse = attach_pulse_reg;
  assign change_pulse = change_pulse_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_attach_count;
    attach_pulse_reg |-> $past(cnt_next) == $past(asr_need(match_field));
  endproperty
  a_attach_count: assert property (p_attach_count) else $error("attach count wrong");

  property p_change_count;
    change_pulse_reg |-> $past(cnt_next) == $past(asr_need({1'b0, check_field}));
  endproperty
  a_change_count: assert property (p_change_count) else $error("change count wrong");

  c_attach: cover property (attach_pulse_reg);
  c_change: cover property (change_pulse_reg);
endmodule

`default_nettype wire

// ### asr_top.sv
// Accessory switch register bank with routing, charger signalling and ID tuning.
//
// Behaviour
// - Device-type bit 5 is one while a charging dock is detected.
// - Device-type bits 2, 1, 0 report dedicated, charging, standard downstream ports.
// - Raw 8-bit ID resistance value reads from its own read-only register.
// - Negative-data field 7:5 selects open, host one, left audio or host two.
// - Positive-data field 4:2 selects open, host one, right audio, host two, microphone.
// - Power field 1:0 selects open, rail to microphone, rail to output; 01 unused.
// - Manual routing applies only while the manual route enable bit is set.
// - The input-to-output power switch closes only while the input rail is valid.
// - Force bit drives charger detect low; otherwise low for charger type attachments.
// - Charge control bit 3 enables the microphone over-voltage guard.
// - Charge control bit 2 forces 0.6 V on positive data while rail valid.
// - Charge control bits 4, 3, 2 act regardless of manual route enable.
// - Attach needs match field plus one consecutive matching ID readings.
// - A resistor-code change needs check field plus one ID checks.
// - Capacitance field 1:0 selects the assumed ID line capacitance.
//
// The Avalon-MM register port is this design's own decision.
`default_nettype none

module asr_top
  import asr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Avalon-MM slave.
  input wire logic [asr_pkg::ASR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Detection results from the analog front end.
  input wire logic dock_detected,
  input wire logic dcp_detected,
  input wire logic cdp_detected,
  input wire logic sdp_detected,
  input wire logic aca_detected,
  input wire logic carkit_detected,
  input wire logic input_power_rail_valid,
  input wire logic id_sample_valid,
  input wire logic [7:0] id_resistance_raw_value,
  input wire logic [4:0] id_code,
  // Switch controls, high closes the switch.
  output logic neg_data_host_one_close,
  output logic neg_data_audio_left_close,
  output logic neg_data_host_two_close,
  output logic pos_data_host_one_close,
  output logic pos_data_audio_right_close,
  output logic pos_data_host_two_close,
  output logic pos_data_microphone_close,
  output logic input_rail_microphone_close,
  output logic input_rail_output_close,
  // Charger signalling and ID tuning.
  output logic charger_detect_out_n,
  output logic microphone_overvolt_guard_enable,
  output logic pos_data_force_0v6,
  output logic [1:0] id_cap_select,
  output logic id_attached,
  // Interrupt.
  output logic irq
);
  // ==========================================================================
  // Register bus slave
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_go;
  logic [7:0] wbyte;
  logic [7:0] control_reg;
  logic [7:0] type_reg;
  logic [7:0] raw_reg;
  logic [7:0] route_reg;
  logic [7:0] charge_reg;
  logic [7:0] match_reg;
  logic [7:0] tune_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [7:0] irq_mask_reg;

  // One wait state: the request is seen, then waitrequest drops for one cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign wr_go = avs_write && !wait_reg;
  assign wbyte = avs_writedata[7:0];

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      ASR_IDX_CONTROL: rdata_next[7:0] = control_reg;
      ASR_IDX_TYPE: rdata_next[7:0] = type_reg;
      ASR_IDX_RAW: rdata_next[7:0] = raw_reg;
      ASR_IDX_ROUTE: rdata_next[7:0] = route_reg;
      ASR_IDX_CHARGE: rdata_next[7:0] = charge_reg;
      ASR_IDX_MATCH: rdata_next[7:0] = match_reg;
      ASR_IDX_TUNE: rdata_next[7:0] = tune_reg;
      ASR_IDX_IRQ_STATUS: rdata_next[7:0] = irq_status_reg;
      ASR_IDX_IRQ_MASK: rdata_next[7:0] = irq_mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      control_reg <= ASR_RST_CONTROL;
      route_reg <= ASR_RST_ROUTE;
      charge_reg <= ASR_RST_CHARGE;
      match_reg <= ASR_RST_MATCH;
      tune_reg <= ASR_RST_TUNE;
      irq_mask_reg <= ASR_RST_IRQ_MASK;
    end else if (wr_go) begin
      case (avs_address)
        ASR_IDX_CONTROL: control_reg <= wbyte & ASR_WMASK_CONTROL;
        ASR_IDX_ROUTE: route_reg <= wbyte & ASR_WMASK_ROUTE;
        ASR_IDX_CHARGE: charge_reg <= wbyte & ASR_WMASK_CHARGE;
        ASR_IDX_MATCH: match_reg <= wbyte & ASR_WMASK_MATCH;
        ASR_IDX_TUNE: tune_reg <= wbyte & ASR_WMASK_TUNE;
        ASR_IDX_IRQ_MASK: irq_mask_reg <= wbyte & ASR_WMASK_IRQ;
        default: control_reg <= control_reg;
      endcase
    end
  end

  // ==========================================================================
  // Detection state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      type_reg <= 8'h00;
    end else begin
      type_reg <= 8'h00;
      type_reg[ASR_TYPE_DOCK] <= dock_detected;
      type_reg[ASR_TYPE_DCP] <= dcp_detected;
      type_reg[ASR_TYPE_CDP] <= cdp_detected;
      type_reg[ASR_TYPE_SDP] <= sdp_detected;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      raw_reg <= 8'h00;
    end else if (id_sample_valid) begin
      raw_reg <= id_resistance_raw_value;
    end
  end

  logic attach_pulse;
  logic change_pulse;
  logic attached_w;

  asr_id_filter #(
    .CODE_W(5)
  ) u_filter (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample_valid(id_sample_valid),
    .sample_code(id_code),
    .match_field(match_reg[ASR_MATCH_LSB +: 3]),
    .check_field(tune_reg[ASR_CHECK_LSB +: 2]),
    .attached(attached_w),
    .attach_pulse(attach_pulse),
    .change_pulse(change_pulse)
  );

  // ==========================================================================
  // Routing and charger signalling
  logic route_en;
  logic [2:0] neg_sel;
  logic [2:0] pos_sel;
  logic [1:0] pwr_sel;
  logic neg_h1_reg;
  logic neg_al_reg;
  logic neg_h2_reg;
  logic pos_h1_reg;
  logic pos_ar_reg;
  logic pos_h2_reg;
  logic pos_mic_reg;
  logic pwr_mic_reg;
  logic pwr_out_reg;
  logic chg_det_n_reg;
  logic mic_guard_reg;
  logic force_0v6_reg;
  logic [1:0] cap_reg;
  logic attached_reg;

  assign route_en = control_reg[ASR_CTRL_ROUTE_EN];
  assign neg_sel = route_reg[ASR_NEG_LSB +: 3];
  assign pos_sel = route_reg[ASR_POS_LSB +: 3];
  assign pwr_sel = route_reg[ASR_PWR_LSB +: 2];

  // With manual routing off every switch here stays open.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      neg_h1_reg <= 1'b0;
      neg_al_reg <= 1'b0;
      neg_h2_reg <= 1'b0;
      pos_h1_reg <= 1'b0;
      pos_ar_reg <= 1'b0;
      pos_h2_reg <= 1'b0;
      pos_mic_reg <= 1'b0;
      pwr_mic_reg <= 1'b0;
      pwr_out_reg <= 1'b0;
    end else begin
      neg_h1_reg <= route_en && neg_sel == ASR_DATA_HOST1;
      neg_al_reg <= route_en && neg_sel == ASR_DATA_AUDIO;
      neg_h2_reg <= route_en && neg_sel == ASR_DATA_HOST2;
      pos_h1_reg <= route_en && pos_sel == ASR_DATA_HOST1;
      pos_ar_reg <= route_en && pos_sel == ASR_DATA_AUDIO;
      pos_h2_reg <= route_en && pos_sel == ASR_DATA_HOST2;
      pos_mic_reg <= route_en && pos_sel == ASR_DATA_MIC;
      pwr_mic_reg <= route_en && pwr_sel == ASR_PWR_MIC;
      pwr_out_reg <= route_en && pwr_sel == ASR_PWR_OUT && input_power_rail_valid;
    end
  end

  // These controls ignore the manual route enable.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chg_det_n_reg <= 1'b1;
      mic_guard_reg <= 1'b0;
      force_0v6_reg <= 1'b0;
      cap_reg <= 2'h0;
      attached_reg <= 1'b0;
    end else begin
      chg_det_n_reg <= !(charge_reg[ASR_CHG_FORCE_DET] || dcp_detected || cdp_detected
                         || aca_detected || carkit_detected);
      mic_guard_reg <= charge_reg[ASR_CHG_MIC_GUARD];
      force_0v6_reg <= charge_reg[ASR_CHG_FORCE_0V6] && input_power_rail_valid;
      cap_reg <= tune_reg[ASR_CAP_LSB +: 2];
      attached_reg <= attached_w;
    end
  end

  // ==========================================================================
  // Interrupts
  logic rail_valid_d;
  logic [7:0] irq_events;
  logic [7:0] irq_clear;
  logic irq_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rail_valid_d <= 1'b0;
    end else begin
      rail_valid_d <= input_power_rail_valid;
    end
  end

  always_comb begin
    irq_events = 8'h00;
    irq_events[ASR_IRQ_ATTACH] = attach_pulse;
    irq_events[ASR_IRQ_CODE] = change_pulse;
    irq_events[ASR_IRQ_RAIL] = input_power_rail_valid != rail_valid_d;
    irq_clear = (wr_go && avs_address == ASR_IDX_IRQ_STATUS) ? wbyte : 8'h00;
    // A new event wins over a clear in the same cycle.
    irq_status_next = ((irq_status_reg & ~irq_clear) | irq_events) & ASR_WMASK_IRQ;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_status_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_next & ~irq_mask_reg);
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign neg_data_host_one_close = neg_h1_reg;
  assign neg_data_audio_left_close = neg_al_reg;
  assign neg_data_host_two_close = neg_h2_reg;
  assign pos_data_host_one_close = pos_h1_reg;
  assign pos_data_audio_right_close = pos_ar_reg;
  assign pos_data_host_two_close = pos_h2_reg;
  assign pos_data_microphone_close = pos_mic_reg;
  assign input_rail_microphone_close = pwr_mic_reg;
  assign input_rail_output_close = pwr_out_reg;
  assign charger_detect_out_n = chg_det_n_reg;
  assign microphone_overvolt_guard_enable = mic_guard_reg;
  assign pos_data_force_0v6 = force_0v6_reg;
  assign id_cap_select = cap_reg;
  assign id_attached = attached_reg;
  assign irq = irq_reg;

  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_dock;
    ##1 type_reg[ASR_TYPE_DOCK] == $past(dock_detected);
  endproperty
  a_dock: assert property (p_dock) else $error("dock flag wrong");

  property p_ports;
    ##1 type_reg[2:0] == $past({dcp_detected, cdp_detected, sdp_detected});
  endproperty
  a_ports: assert property (p_ports) else $error("port type flags wrong");

  property p_raw;
    id_sample_valid ##1 (!id_sample_valid)[*2] |-> raw_reg == $past(id_resistance_raw_value, 2);
  endproperty
  a_raw: assert property (p_raw) else $error("raw value not held");

  property p_neg_route;
    route_en && neg_sel == ASR_DATA_HOST1
      |=> neg_data_host_one_close && !neg_data_audio_left_close && !neg_data_host_two_close;
  endproperty
  a_neg_route: assert property (p_neg_route) else $error("negative route wrong");

  property p_pos_mic;
    route_en && pos_sel == ASR_DATA_MIC
      |=> pos_data_microphone_close && !pos_data_host_one_close && !pos_data_audio_right_close;
  endproperty
  a_pos_mic: assert property (p_pos_mic) else $error("microphone route wrong");

  property p_pwr_open;
    pwr_sel == ASR_PWR_OPEN || pwr_sel == 2'h1
      |=> !input_rail_microphone_close && !input_rail_output_close;
  endproperty
  a_pwr_open: assert property (p_pwr_open) else $error("power switch closed");

  property p_manual_off;
    !route_en |=> !(neg_data_host_one_close || neg_data_host_two_close
                    || pos_data_host_one_close || pos_data_microphone_close
                    || input_rail_microphone_close);
  endproperty
  a_manual_off: assert property (p_manual_off) else $error("route without enable");

  property p_rail_gate;
    input_rail_output_close |-> $past(input_power_rail_valid) && $past(route_en);
  endproperty
  a_rail_gate: assert property (p_rail_gate) else $error("power closed without rail");

  property p_force_det;
    charge_reg[ASR_CHG_FORCE_DET] |=> !charger_detect_out_n;
  endproperty
  a_force_det: assert property (p_force_det) else $error("charger detect not forced");

  property p_force_0v6;
    pos_data_force_0v6 |-> $past(charge_reg[ASR_CHG_FORCE_0V6]) && $past(input_power_rail_valid);
  endproperty
  a_force_0v6: assert property (p_force_0v6) else $error("0.6 V forced wrongly");

  property p_reserved;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000
      && (avs_address != ASR_IDX_CHARGE || avs_readdata[7:0] == (avs_readdata[7:0] & 8'h1c));
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  c_route: cover property (route_en && pwr_sel == ASR_PWR_OUT ##1 input_rail_output_close);
  c_irq: cover property ($rose(irq));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule

`default_nettype wire

// ### asr_accessory_model.sv
// Accessory front end model that delivers ID readings to the register block.
`default_nettype none

module asr_accessory_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Requests from the bench.
  input wire logic send,
  input wire logic [4:0] code,
  input wire logic [7:0] raw,
  // Readings towards the block.
  output logic id_sample_valid,
  output logic [4:0] id_code,
  output logic [7:0] id_resistance_raw_value
);
  timeunit 1ns;
  timeprecision 1ns;

  // Between readings the lines toggle so nothing can rely on a held value.
  always_ff @(posedge clk_sys) begin
    id_sample_valid <= send && !srst;
    if (srst) begin
      id_code <= 5'h00;
      id_resistance_raw_value <= 8'h00;
    end else if (send) begin
      id_code <= code;
      id_resistance_raw_value <= raw;
    end else begin
      id_code <= ~id_code;
      id_resistance_raw_value <= ~id_resistance_raw_value;
    end
  end
endmodule

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the accessory switch register block.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import asr_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
  logic avs_waitrequest, rail = 1'b0, send = 1'b0, chg_n, guard, f06, att, irq, isv;
  logic [5:0] det = 6'h00;
  logic [4:0] code = 5'h00, icode;
  logic [7:0] raw = 8'h00, iraw, d;
  logic [8:0] sw;
  logic [1:0] cap, capx;
  logic [7:0] mdl [0:63];
  logic [5:0] addrs [0:9] = '{6'h02, 6'h0a, 6'h0b, 6'h13, 6'h14, 6'h1b, 6'h1c, 6'h20,
    6'h21, 6'h3f};
  int failures = 0, check_count = 0, c;

  always #25 clk_sys = ~clk_sys;

  asr_accessory_model acc (.clk_sys(clk_sys), .srst(srst), .send(send), .code(code),
    .raw(raw), .id_sample_valid(isv), .id_code(icode), .id_resistance_raw_value(iraw));

  asr_top dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dock_detected(det[5]), .dcp_detected(det[4]), .cdp_detected(det[3]),
    .sdp_detected(det[2]), .aca_detected(det[1]), .carkit_detected(det[0]),
    .input_power_rail_valid(rail), .id_sample_valid(isv),
    .id_resistance_raw_value(iraw), .id_code(icode),
    .neg_data_host_one_close(sw[8]), .neg_data_audio_left_close(sw[7]),
    .neg_data_host_two_close(sw[6]), .pos_data_host_one_close(sw[5]),
    .pos_data_audio_right_close(sw[4]), .pos_data_host_two_close(sw[3]),
    .pos_data_microphone_close(sw[2]), .input_rail_microphone_close(sw[1]),
    .input_rail_output_close(sw[0]), .charger_detect_out_n(chg_n),
    .microphone_overvolt_guard_enable(guard), .pos_data_force_0v6(f06),
    .id_cap_select(cap), .id_attached(att), .irq(irq));

  // ==========================================================================
  // Bus, model and reporting tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] wm(input logic [5:0] a);
    case (a)
      ASR_IDX_CONTROL: wm = ASR_WMASK_CONTROL;
      ASR_IDX_ROUTE: wm = ASR_WMASK_ROUTE;
      ASR_IDX_CHARGE: wm = ASR_WMASK_CHARGE;
      ASR_IDX_MATCH: wm = ASR_WMASK_MATCH;
      ASR_IDX_TUNE: wm = ASR_WMASK_TUNE;
      ASR_IDX_IRQ_MASK: wm = ASR_WMASK_IRQ;
      default: wm = 8'h00;
    endcase
  endfunction

  // Requests are held until waitrequest is seen low, then released at that same edge.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] v);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, v};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
    mdl[a] = v & wm(a);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rdv, {24'h0, e})
  endtask

  // One reading, followed by a random pause of one to two cycles.
  task automatic sample(input logic [4:0] k);
    code <= k;
    raw <= 8'($urandom);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat ($urandom_range(2, 1)) @(posedge clk_sys);
  endtask

  function automatic logic [8:0] exp_sw(input logic [7:0] r, input logic en, input logic v);
    exp_sw = en ? {r[7:5] == 3'h1, r[7:5] == 3'h2, r[7:5] == 3'h3, r[4:2] == 3'h1,
      r[4:2] == 3'h2, r[4:2] == 3'h3, r[4:2] == 3'h4, r[1:0] == 2'h2,
      r[1:0] == 2'h3 && v} : 9'h000;
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hf8a1));
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[ASR_IDX_ROUTE] = 8'h27;
    mdl[ASR_IDX_MATCH] = 8'h08;
    mdl[ASR_IDX_TUNE] = 8'h05;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    foreach (addrs[i]) rd_chk(addrs[i], mdl[addrs[i]]);
    $display("test reset values done");
    foreach (addrs[i]) begin
      d = 8'($urandom);
      if (addrs[i] == ASR_IDX_ROUTE) begin
        d[0] = d[0] & d[1];
        wr(addrs[i], 8'h00);
      end
      wr(addrs[i], d);
      rd_chk(addrs[i], mdl[addrs[i]]);
    end
    wr(ASR_IDX_IRQ_MASK, 8'h00);
    $display("test access kinds done");
    repeat (8) begin
      det <= 6'($urandom);
      repeat (2) @(posedge clk_sys);
      rd_chk(ASR_IDX_TYPE, {2'b00, det[5], 2'b00, det[4:2]});
    end
    sample(5'h00);
    rd_chk(ASR_IDX_RAW, raw);
    $display("test type and raw done");
    wr(ASR_IDX_CONTROL, 8'h01);
    for (int n = 0; n < 4; n++) begin
      for (int p = 0; p < 5; p++) begin
        for (int w = 0; w < 4; w++) begin
          if (w != 1) begin
            wr(ASR_IDX_ROUTE, 8'h00);
            wr(ASR_IDX_ROUTE, {n[2:0], p[2:0], w[1:0]});
            rail <= 1'($urandom);
            repeat (3) @(posedge clk_sys);
            `CHK(sw, exp_sw(mdl[ASR_IDX_ROUTE], 1'b1, rail))
          end
        end
      end
    end
    wr(ASR_IDX_CONTROL, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK(sw, 9'h000)
    $display("test routing done");
    for (int k = 0; k < 16; k++) begin
      wr(ASR_IDX_CONTROL, {7'h00, k[3]});
      wr(ASR_IDX_CHARGE, {3'b000, k[2:0], 2'b00});
      det <= 6'($urandom);
      rail <= 1'($urandom);
      repeat (3) @(posedge clk_sys);
      d = {5'h00, !(k[2] | det[4] | det[3] | det[1] | det[0]), k[1], k[0] & rail};
      `CHK({chg_n, guard, f06}, d[2:0])
    end
    $display("test charge signalling done");
    wr(ASR_IDX_IRQ_STATUS, 8'h07);
    for (int f = 0; f < 8; f++) begin
      c = $urandom_range(3, 0);
      capx = 2'($urandom);
      wr(ASR_IDX_MATCH, {3'b000, f[2:0], 2'b00});
      wr(ASR_IDX_TUNE, {4'h0, c[1:0], capx});
      @(posedge clk_sys);
      `CHK(cap, capx)
      repeat (f) sample(5'h0b);
      repeat (3) @(posedge clk_sys);
      `CHK(att, 1'b0)
      sample(5'h0b);
      repeat (3) @(posedge clk_sys);
      `CHK({att, irq}, 2'b11)
      rd_chk(ASR_IDX_IRQ_STATUS, 8'h01);
      wr(ASR_IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      wr(ASR_IDX_IRQ_STATUS, 8'h01);
      wr(ASR_IDX_IRQ_MASK, 8'h00);
      rd_chk(ASR_IDX_IRQ_STATUS, 8'h00);
      repeat (c) sample(5'h00);
      repeat (3) @(posedge clk_sys);
      `CHK(att, 1'b1)
      sample(5'h00);
      repeat (3) @(posedge clk_sys);
      `CHK({att, irq}, 2'b01)
      rd_chk(ASR_IDX_IRQ_STATUS, 8'h02);
      wr(ASR_IDX_IRQ_STATUS, 8'h02);
    end
    $display("test id filter done");
    finish_test();
  end
endmodule

`default_nettype wire
